// ==== hw/e1_rx_alarm_defines.svh ====
// Constants of the E1 receive alarm monitor: map, fields, counts.
// Assumes inclusion by bare name.
`ifndef E1_RX_ALARM_DEFINES_SVH
`define E1_RX_ALARM_DEFINES_SVH

// Register indices on the host port
`define RA_STATUS_ADDR    4'h0
`define RA_MASK_ADDR      4'h1
`define RA_CONTROL_ADDR   4'h2
`define RA_BV_COUNT_ADDR  4'h3
`define RA_CRC_COUNT_ADDR 4'h4
`define RA_FE_COUNT_ADDR  4'h5

// Status and mask bit positions
`define RA_BIT_REMOTE     7
`define RA_BIT_DMA        6
`define RA_BIT_SIG_ONES   5
`define RA_BIT_UNF_ONES   4
`define RA_BIT_FRAME_CRIT 3
`define RA_BIT_MF_CRIT    2
`define RA_BIT_SYNC_LOSS  1
`define RA_BIT_SATURATED  0

// Control bit that blocks automatic resync
`define RA_CTRL_RESYNC_DIS 1

// Reset values
`define RA_STATUS_RST     8'h00
`define RA_MASK_RST       8'h00
`define RA_CONTROL_RST    8'h00

// Frame positions (bit index 0 is the first bit of a slot)
`define RA_TS_ALIGN       5'h00
`define RA_TS_SIG         5'h10
`define RA_TS_LAST        5'h1F
`define RA_BIT_IDX_A      3'h2
`define RA_BIT_IDX_Y      3'h5
`define RA_BIT_IDX_LAST   3'h7

// Counts
`define RA_RUN_LEN        2'h3
`define RA_SIG_FRAMES     2'h2
`define RA_UNF_ZEROS      3'h3
`define RA_LOS_ZEROS      6'h20
`define RA_COUNT_FULL     8'hFF

`endif

// ==== hw/e1_rx_alarm_pkg.sv ====
// Types of the E1 receive alarm monitor and its bench.
// Assumes nothing of its surroundings.
package e1_rx_alarm_pkg;
    typedef logic [3:0] reg_addr_t;  // Register index
    typedef logic [7:0] reg_data_t;  // Register data
    typedef logic [4:0] slot_t;      // Time slot number
    typedef logic [2:0] bit_idx_t;   // Bit within a slot
    typedef logic [3:0] frame_t;     // Frame within multiframe
endpackage

// ==== hw/e1_receive_alarm_monitor.sv ====
// E1 receive alarm monitor: alarm outputs, latched status,
// interrupt mask and three saturating error counters.
// Assumes framer strobes and positions synchronous to i_ref_clk,
// one i_bit_valid per bit, host strobes never overlapping.
//
// Functional notes
// - Remote alarm after three set, three clear
// - Multiframe alarm by three-multiframe filter
// - Status remote bit latches remote alarm
// - Status latches sync loss and multiframe alarm
// - Signaling ones after two all-ones slots
// - Unframed ones when fewer than three zeros
// - Frame criterion sets flag, starts resync
// - Multiframe criterion sets flag, starts resync
// - Sync loss high while resync runs
// - Multiframe alarm detected in CAS and CCS
// - Violation pulse one clock cycle long
// - Count every bipolar violation
// - Carrier loss after 32 zeros
// - Framing error on any word error
// - Frame and CRC errors counted separately
// - Mask matches status, one enables
// - Reset clears all but counters, resyncs
// - Violation count is eight-bit binary
// - Status read clears inactive bits
// - Enabled status bits raise interrupt
// - Counters saturate, further errors flag it
// - Frame and CRC counts pause during resync
`timescale 1ns/100ps
`include "e1_rx_alarm_defines.svh"

module e1_receive_alarm_monitor #(
    parameter int CW = 8              // Error counter width
) (
    // Clock and reset
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_resetn,
    // Received bit stream and position
    input  wire logic                      i_bit_valid,
    input  wire logic                      i_line_pos_in,
    input  wire logic                      i_line_neg_in,
    input  wire logic                      i_bit_data,
    input  wire logic                      i_bit_violation,
    input  wire e1_rx_alarm_pkg::slot_t    i_slot,
    input  wire e1_rx_alarm_pkg::bit_idx_t i_bit_idx,
    input  wire e1_rx_alarm_pkg::frame_t   i_frame,
    input  wire logic                      i_align_frame,
    // Synchronizer events
    input  wire logic                      i_faw_error,
    input  wire logic                      i_casmf_error,
    input  wire logic                      i_crc4_error,
    input  wire logic                      i_frame_crit,
    input  wire logic                      i_mf_crit,
    input  wire logic                      i_sync_found,
    // Host register port
    input  wire e1_rx_alarm_pkg::reg_addr_t i_addr,
    input  wire e1_rx_alarm_pkg::reg_data_t i_wdata,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    output logic [7:0]                     o_rdata,
    // Alarm outputs
    output logic                           o_sync_loss,
    output logic                           o_remote_alarm,
    output logic                           o_distant_multiframe_alarm,
    output logic                           o_carrier_loss,
    output logic                           o_framing_error_out,
    output logic                           o_bipolar_violation_pulse,
    output logic                           o_resync_start,
    output logic                           o_interrupt
);
    import e1_rx_alarm_pkg::*;
    ////////////////////////////////////////////////////////////////////
    // Functions
    // Three-in-a-row filter: {state, run of opposite samples}
    function automatic logic [2:0] run3(input logic [2:0] st,
                                        input logic       smp);
        logic [1:0] run;
        run = st[1:0];
        if (smp == st[2]) begin
            run3 = {st[2], 2'h0};
        end else if (run + 2'h1 == `RA_RUN_LEN) begin
            run3 = {smp, 2'h0};
        end else begin
            run3 = {st[2], run + 2'h1};
        end
    endfunction
    // Saturating up count
    function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
        sat_inc = (&v) ? v : v + 1'b1;
    endfunction
    ////////////////////////////////////////////////////////////////////
    // Declarations
    reg_data_t    status;            // Latched alarm status
    reg_data_t    mask;              // Interrupt enables
    reg_data_t    control;           // Resync control
    logic [CW-1:0] bv_count;         // Bipolar violation count
    logic [CW-1:0] crc_count;        // CRC4 error count
    logic [CW-1:0] fe_count;         // Frame alignment error count
    logic [1:0]   remote_run;        // Remote alarm filter run
    logic [1:0]   dma_run;           // Multiframe alarm filter run
    logic [1:0]   sig_frames;        // All-ones slot 16 frames seen
    logic         sig_slot_ones;     // Slot 16 ones so far
    logic         signaling_all_ones;
    logic [2:0]   zeros_now;         // Zeros in frame, saturating
    logic [2:0]   zeros_align;       // Zeros in last align frame
    logic [2:0]   zeros_nonalign;    // Zeros in last non-align frame
    logic         unframed_all_ones;
    logic [5:0]   zero_run;          // Consecutive line zeros
    logic         frame_end;         // Last bit of a frame
    logic         sig_end;           // Last bit of slot 16
    logic         crit_start;        // Criterion asks for resync
    logic         bv_event;
    logic         crc_event;
    logic         fe_event;
    logic         saturated_any;     // A counter sits at full
    logic         saturate_event;    // Counter hit or over full
    reg_data_t    active;            // Conditions still present
    reg_data_t    set_now;           // Bits to set this cycle
    logic [2:0]   next_remote;
    logic [2:0]   next_dma;
    ////////////////////////////////////////////////////////////////////
    // Event decode
    // Frame and slot boundaries
    assign frame_end  = i_bit_valid && i_slot == `RA_TS_LAST &&
                        i_bit_idx == `RA_BIT_IDX_LAST;
    assign sig_end    = i_bit_valid && i_slot == `RA_TS_SIG &&
                        i_bit_idx == `RA_BIT_IDX_LAST;
    // Resync is blocked by the control bit
    assign crit_start = (i_frame_crit || i_mf_crit) &&
                        !control[`RA_CTRL_RESYNC_DIS];
    // Counter events
    assign bv_event   = i_bit_valid && i_bit_violation;
    assign crc_event  = i_crc4_error && !o_sync_loss;
    assign fe_event   = i_faw_error && !o_sync_loss;
    assign saturated_any = (&bv_count) || (&crc_count) || (&fe_count);
    // Reaching full (count at FE or FF when an error comes)
    assign saturate_event =
        (bv_event  && &bv_count[CW-1:1])  ||
        (crc_event && &crc_count[CW-1:1]) ||
        (fe_event  && &fe_count[CW-1:1]);
    // Filter steps
    assign next_remote = run3({o_remote_alarm, remote_run}, i_bit_data);
    assign next_dma    = run3({o_distant_multiframe_alarm, dma_run},
                              i_bit_data);
    ////////////////////////////////////////////////////////////////////
    // Status set and hold terms, in status bit order 7 down to 0
    // Conditions that keep a status bit from clearing on read
    assign active  = {o_remote_alarm, o_distant_multiframe_alarm,
                      signaling_all_ones, unframed_all_ones, i_frame_crit,
                      i_mf_crit, o_sync_loss, saturated_any};
    // Bits set this cycle: levels latch, saturation only as a pulse
    assign set_now = {active[7:1], saturate_event};
    ////////////////////////////////////////////////////////////////////
    // Remote alarm: bit 3 of slot 0 in non-align frames
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_remote_alarm <= 1'b0;
            remote_run     <= 2'h0;
        end else if (i_bit_valid && i_slot == `RA_TS_ALIGN &&
                     i_bit_idx == `RA_BIT_IDX_A && !i_align_frame) begin
            {o_remote_alarm, remote_run} <= next_remote;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Multiframe alarm: bit 6 of slot 16 in frame 0, any signaling mode
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_distant_multiframe_alarm <= 1'b0;
            dma_run                    <= 2'h0;
        end else if (i_bit_valid && i_frame == 4'h0 &&
                     i_slot == `RA_TS_SIG &&
                     i_bit_idx == `RA_BIT_IDX_Y) begin
            // Same filter in CAS and CCS
            {o_distant_multiframe_alarm, dma_run} <= next_dma;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Slot 16 all ones over two frames
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sig_slot_ones      <= 1'b1;
            sig_frames         <= 2'h0;
            signaling_all_ones <= 1'b0;
        end else if (sig_end) begin
            sig_slot_ones <= 1'b1;
            if (sig_slot_ones && i_bit_data) begin
                // Another all-ones slot
                if (sig_frames != `RA_SIG_FRAMES) begin
                    sig_frames <= sig_frames + 2'h1;
                end
                signaling_all_ones <=
                    (sig_frames + 2'h1 >= `RA_SIG_FRAMES);
            end else begin
                sig_frames         <= 2'h0;
                signaling_all_ones <= 1'b0;
            end
        end else if (i_bit_valid && i_slot == `RA_TS_SIG) begin
            sig_slot_ones <= sig_slot_ones & i_bit_data;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Unframed all ones: zeros in last align and non-align frames
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            zeros_now      <= 3'h0;
            zeros_align    <= `RA_UNF_ZEROS;
            zeros_nonalign <= `RA_UNF_ZEROS;
        end else if (i_bit_valid) begin
            if (frame_end) begin
                // Store the finished frame's count, saturated at 3
                if (i_align_frame) begin
                    zeros_align <= (zeros_now < `RA_UNF_ZEROS && !i_bit_data)
                                   ? zeros_now + 3'h1 : zeros_now;
                end else begin
                    zeros_nonalign <= (zeros_now < `RA_UNF_ZEROS &&
                                       !i_bit_data)
                                      ? zeros_now + 3'h1 : zeros_now;
                end
                zeros_now <= 3'h0;
            end else if (!i_bit_data && zeros_now < `RA_UNF_ZEROS) begin
                zeros_now <= zeros_now + 3'h1;
            end
        end
    end
    // Fewer than three zeros across both frames
    assign unframed_all_ones =
        (zeros_align + zeros_nonalign) < `RA_UNF_ZEROS;
    ////////////////////////////////////////////////////////////////////
    // Carrier loss: 32 zeros on both rails
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            zero_run       <= 6'h00;
            o_carrier_loss <= 1'b0;
        end else if (i_bit_valid) begin
            if (i_line_pos_in || i_line_neg_in) begin
                zero_run       <= 6'h00;
                o_carrier_loss <= 1'b0;
            end else if (zero_run != `RA_LOS_ZEROS) begin
                zero_run       <= zero_run + 6'h01;
                o_carrier_loss <= (zero_run + 6'h01 == `RA_LOS_ZEROS);
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Resync control and sync loss
    // Reset holds resync; the synchronizer ends it
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sync_loss    <= 1'b1;
            o_resync_start <= 1'b1;
        end else begin
            o_resync_start <= crit_start;
            if (crit_start) begin
                o_sync_loss <= 1'b1;
            end else if (i_sync_found) begin
                o_sync_loss <= 1'b0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Real-time pulse outputs
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_bipolar_violation_pulse <= 1'b0;
            o_framing_error_out       <= 1'b0;
        end else begin
            o_bipolar_violation_pulse <= bv_event;
            o_framing_error_out <= i_faw_error || i_casmf_error ||
                                   i_crc4_error;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Error counters: survive reset, host writes win over counting
    always_ff @(posedge i_ref_clk) begin
        if (i_wr && i_addr == `RA_BV_COUNT_ADDR) begin
            bv_count <= i_wdata;
        end else if (bv_event) begin
            bv_count <= sat_inc(bv_count);
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (i_wr && i_addr == `RA_CRC_COUNT_ADDR) begin
            crc_count <= i_wdata;
        end else if (crc_event) begin
            crc_count <= sat_inc(crc_count);
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (i_wr && i_addr == `RA_FE_COUNT_ADDR) begin
            fe_count <= i_wdata;
        end else if (fe_event) begin
            fe_count <= sat_inc(fe_count);
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Control and mask registers
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mask    <= `RA_MASK_RST;
            control <= `RA_CONTROL_RST;
        end else if (i_wr) begin
            if (i_addr == `RA_MASK_ADDR) begin
                mask <= i_wdata;
            end else if (i_addr == `RA_CONTROL_ADDR) begin
                control <= i_wdata;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Status: read clears inactive bits, a new set wins over the clear
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            status <= `RA_STATUS_RST;
        end else if (i_rd && i_addr == `RA_STATUS_ADDR) begin
            status <= (status & active) | set_now;
        end else begin
            status <= status | set_now;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Interrupt: any enabled status bit; mask clear drops it at once
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_interrupt <= 1'b0;
        end else begin
            o_interrupt <= |((status | set_now) & mask &
                             ~((i_wr && i_addr == `RA_MASK_ADDR) ?
                               ~i_wdata : 8'h00));
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Read data, valid the cycle after the strobe
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            if (i_addr == `RA_STATUS_ADDR) begin
                o_rdata <= status;
            end else if (i_addr == `RA_MASK_ADDR) begin
                o_rdata <= mask;
            end else if (i_addr == `RA_CONTROL_ADDR) begin
                o_rdata <= control;
            end else if (i_addr == `RA_BV_COUNT_ADDR) begin
                o_rdata <= bv_count;
            end else if (i_addr == `RA_CRC_COUNT_ADDR) begin
                o_rdata <= crc_count;
            end else if (i_addr == `RA_FE_COUNT_ADDR) begin
                o_rdata <= fe_count;
            end else begin
                // Unmapped index reads zero
                o_rdata <= 8'h00;
            end
        end else begin
            o_rdata <= 8'h00;
        end
    end
endmodule

// ==== sim/e1_alarm_checker_properties.sv ====
// Checker: alarm and error outputs against their inputs.
// Assumes binding to the monitor's top, one clock domain.
`timescale 1ns/100ps
`include "e1_rx_alarm_defines.svh"
module e1_alarm_checker (
    // Clock and reset
    input wire logic                       i_ref_clk,
    input wire logic                       i_resetn,
    // Stream and events
    input wire logic                       i_bit_valid,
    input wire logic                       i_line_pos_in,
    input wire logic                       i_line_neg_in,
    input wire logic                       i_bit_violation,
    input wire logic                       i_faw_error,
    input wire logic                       i_casmf_error,
    input wire logic                       i_crc4_error,
    input wire logic                       i_sync_found,
    // Host port
    input wire e1_rx_alarm_pkg::reg_addr_t i_addr,
    input wire e1_rx_alarm_pkg::reg_data_t i_wdata,
    input wire logic                       i_wr,
    // Outputs watched
    input wire logic                       o_sync_loss,
    input wire logic                       o_carrier_loss,
    input wire logic                       o_framing_error_out,
    input wire logic                       o_bipolar_violation_pulse,
    input wire logic                       o_interrupt
);
    import e1_rx_alarm_pkg::*;
    logic       zero_bit;  // Strobed bit with both rails low
    logic [5:0] zero_run;  // Consecutive zero strobes, saturating
    assign zero_bit = i_bit_valid && !i_line_pos_in && !i_line_neg_in;
    ////////////////////////////////////////////////////////////////////
    // Zero strobes in a row, saturating
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            zero_run <= 6'h00;
        end else if (i_bit_valid) begin
            zero_run <= !zero_bit ? 6'h00 :
                        (zero_run == 6'h3F ? 6'h3F : zero_run + 6'h01);
        end
    end
    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_viol;
        i_bit_valid && i_bit_violation;
    endsequence
    sequence s_err;
        i_faw_error || i_casmf_error || i_crc4_error;
    endsequence
    sequence s_mask_off;
        i_wr && i_addr == `RA_MASK_ADDR && i_wdata == 8'h00;
    endsequence
    a_bv_pulse: assert property (s_viol
        |=> o_bipolar_violation_pulse) else $error("violation pulse missing");
    a_bv_single: assert property (!(i_bit_valid && i_bit_violation)
        |=> !o_bipolar_violation_pulse) else $error("stray violation pulse");
    a_fer_follow: assert property (s_err |=> o_framing_error_out)
        else $error("framing error output missing");
    a_fer_quiet: assert property (!(i_faw_error || i_casmf_error
        || i_crc4_error) |=> !o_framing_error_out)
        else $error("stray framing error output");
    a_carrier_set: assert property (zero_bit && zero_run == 6'h1F
        |=> o_carrier_loss) else $error("carrier loss late");
    a_carrier_clear: assert property (i_bit_valid && (i_line_pos_in
        || i_line_neg_in) |=> !o_carrier_loss)
        else $error("carrier loss stuck");
    a_sync_hold: assert property (o_sync_loss && !i_sync_found
        |=> o_sync_loss) else $error("sync loss dropped early");
    a_mask_clear: assert property (s_mask_off |=> !o_interrupt)
        else $error("interrupt survives mask clear");
endmodule
bind e1_receive_alarm_monitor e1_alarm_checker i_chk (.i_ref_clk,
    .i_resetn, .i_bit_valid, .i_line_pos_in, .i_line_neg_in,
    .i_bit_violation, .i_faw_error, .i_casmf_error, .i_crc4_error,
    .i_sync_found, .i_addr, .i_wdata, .i_wr, .o_sync_loss, .o_carrier_loss,
    .o_framing_error_out, .o_bipolar_violation_pulse, .o_interrupt);

// ==== sim/e1_line_model.sv ====
// Line model: one received bit per clock with its position.
// Assumes the bench sets the remote bit; all other bits are zero.
`timescale 1ns/100ps
module e1_line_model (
    // Clock, reset and control
    input  wire logic                 i_clk,
    input  wire logic                 i_rstn,
    input  wire logic                 i_a_bit,
    // Bit stream and position
    output logic                      o_valid,
    output logic                      o_data,
    output e1_rx_alarm_pkg::slot_t    o_slot,
    output e1_rx_alarm_pkg::bit_idx_t o_idx,
    output e1_rx_alarm_pkg::frame_t   o_frame,
    output logic                      o_align
);
    import e1_rx_alarm_pkg::*;
    // Step frame, slot and bit position once per strobe
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_valid <= 1'b0;
            {o_frame, o_slot, o_idx} <= 12'h000;
        end else begin
            o_valid <= 1'b1;
            if (o_valid) begin
                {o_frame, o_slot, o_idx} <=
                    {o_frame, o_slot, o_idx} + 12'h001;
            end
        end
    end
    // Even frames align; remote bit in odd ones only
    assign o_align = ~o_frame[0];
    assign o_data  = o_valid && o_slot == 5'h00 && o_idx == 3'h2 &&
                     !o_align && i_a_bit;
endmodule

// ==== sim/testbench.sv ====
// Bench: host register tasks, event pulses and the line model.
// Assumes package, design, checker and model compile first.
`timescale 1ns/100ps
`include "e1_rx_alarm_defines.svh"
module testbench;
    import e1_rx_alarm_pkg::*;
    logic       clk, rstn, wr, rd, a_bit;     // Clock, reset, strobes
    reg_addr_t  addr;                         // Host register index
    reg_data_t  wdata, rdata;                 // Host data
    logic [6:0] ev;       // viol, faw, crc, fcrit, mcrit, found, cas
    logic       valid, data, align, sync_loss, remote, irq, rstart;
    slot_t      slot;                         // Stream position
    bit_idx_t   idx;
    frame_t     frame;
    int         fails = 0;                    // Mismatch count
    int         samples_checked = 0;          // Comparison count
    e1_line_model i_line (.i_clk(clk), .i_rstn(rstn), .i_a_bit(a_bit),
        .o_valid(valid), .o_data(data), .o_slot(slot), .o_idx(idx),
        .o_frame(frame), .o_align(align));
    e1_receive_alarm_monitor i_dut (.i_ref_clk(clk), .i_resetn(rstn),
        .i_bit_valid(valid), .i_line_pos_in(data), .i_line_neg_in(1'b0),
        .i_bit_data(data), .i_bit_violation(ev[0]), .i_slot(slot),
        .i_bit_idx(idx), .i_frame(frame), .i_align_frame(align),
        .i_faw_error(ev[1]), .i_casmf_error(ev[6]), .i_crc4_error(ev[2]),
        .i_frame_crit(ev[3]), .i_mf_crit(ev[4]), .i_sync_found(ev[5]),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_sync_loss(sync_loss), .o_remote_alarm(remote),
        .o_distant_multiframe_alarm(), .o_carrier_loss(),
        .o_framing_error_out(), .o_bipolar_violation_pulse(),
        .o_resync_start(rstart), .o_interrupt(irq));
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////
    // Compare and count mismatches
    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One-cycle register write
    task automatic wr_reg(input reg_addr_t a, input reg_data_t d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // One-cycle read; the next cycle's data compared under mask
    task automatic rd_chk(input string nm, input reg_addr_t a,
                          input reg_data_t e, input reg_data_t m = 8'hFF);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(nm, rdata & m, e);
    endtask
    // One-cycle event pulse
    task automatic pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev <= 7'h00;
        #1;
    endtask
    // Bounded wait for the remote alarm level
    task automatic wait_remote(input logic want);
        for (int n = 0; n < 4000 && remote !== want; n++) @(posedge clk);
        if (remote !== want) begin
            fails++;
            end_of_test();
        end
    endtask
    // Counts, verdict and end of run
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        {rstn, wr, rd, a_bit} = 4'h0;
        addr  = 4'h0;
        wdata = 8'h00;
        ev    = 7'h00;
        repeat (12) @(posedge clk);  // Reset held at power-up
        rstn <= 1'b1;
        wr_reg(`RA_BV_COUNT_ADDR, 8'hFE);   // Preset counters
        wr_reg(`RA_CRC_COUNT_ADDR, 8'h00);
        wr_reg(`RA_FE_COUNT_ADDR, 8'h00);
        wr_reg(`RA_CONTROL_ADDR, 8'h00);
        wr_reg(`RA_MASK_ADDR, 8'hA5);
        rd_chk("mask", `RA_MASK_ADDR, 8'hA5);
        rd_chk("unmapped", 4'h9, 8'h00);
        wr_reg(`RA_STATUS_ADDR, 8'hFF);
        rd_chk("status", `RA_STATUS_ADDR, 8'h02);
        chk("sync loss", 8'(sync_loss), 8'h01);
        pulse(1);
        rd_chk("fe count", `RA_FE_COUNT_ADDR, 8'h00);
        pulse(5);
        chk("sync loss", 8'(sync_loss), 8'h00);
        rd_chk("status", `RA_STATUS_ADDR, 8'h02);
        rd_chk("status", `RA_STATUS_ADDR, 8'h00);
        pulse(1);
        pulse(6);
        pulse(2);
        rd_chk("fe count", `RA_FE_COUNT_ADDR, 8'h01);
        rd_chk("crc count", `RA_CRC_COUNT_ADDR, 8'h01);
        pulse(0);
        rd_chk("bv count", `RA_BV_COUNT_ADDR, 8'hFF);
        pulse(0);
        rd_chk("bv count", `RA_BV_COUNT_ADDR, 8'hFF);
        wr_reg(`RA_MASK_ADDR, 8'h01);
        @(posedge clk);
        #1 chk("interrupt", 8'(irq), 8'h01);
        wr_reg(`RA_MASK_ADDR, 8'h00);
        @(posedge clk);
        #1 chk("interrupt", 8'(irq), 8'h00);
        rd_chk("status", `RA_STATUS_ADDR, 8'h01, 8'h01);
        pulse(3);
        chk("resync start", 8'(rstart), 8'h01);
        chk("sync loss", 8'(sync_loss), 8'h01);
        rd_chk("status", `RA_STATUS_ADDR, 8'h0A, 8'h0E);
        pulse(1);
        rd_chk("fe count", `RA_FE_COUNT_ADDR, 8'h01);
        wr_reg(`RA_CONTROL_ADDR, 8'h02);
        pulse(4);
        chk("resync start", 8'(rstart), 8'h00);
        pulse(5);
        rd_chk("status", `RA_STATUS_ADDR, 8'h04, 8'h04);
        @(posedge clk);
        a_bit <= 1'b1;
        wait_remote(1'b1);
        rd_chk("status", `RA_STATUS_ADDR, 8'h80, 8'h80);
        @(posedge clk);
        a_bit <= 1'b0;
        wait_remote(1'b0);
        rd_chk("status", `RA_STATUS_ADDR, 8'h80, 8'h80);
        rd_chk("status", `RA_STATUS_ADDR, 8'h00, 8'h80);
        end_of_test();
    end
endmodule
